// ==== hw/spci_defines.svh ====
// Constants of the SDRAM pin command interface
`ifndef SPCI_DEFINES_SVH
`define SPCI_DEFINES_SVH
`define SPCI_DATA_W      16
`define SPCI_ROW_W       12
`define SPCI_COL_W       8
`define SPCI_BANK_W      2
`define SPCI_PRE_BIT     10
`define SPCI_RD_MASK_LAT 2
`define SPCI_FIFO_DEPTH  4
`define SPCI_EXIT_NOPS   2
`endif

// ==== hw/spci_pkg.sv ====
// Types of the SDRAM pin command interface
`include "spci_defines.svh"
package spci_pkg;
  typedef enum logic [2:0] {
    SPCI_CMD_LMR, SPCI_CMD_REF, SPCI_CMD_PRE, SPCI_CMD_ACT,
    SPCI_CMD_WR, SPCI_CMD_RD, SPCI_CMD_BST, SPCI_CMD_NOP
  } spci_cmd_t;

  typedef enum logic [1:0] {
    SPCI_RUN, SPCI_POWER_DOWN, SPCI_SUSPEND, SPCI_SELF_REFRESH
  } spci_mode_t;

  typedef struct packed {
    logic [`SPCI_DATA_W-1:0] data;
    logic [1:0]              mask;
  } spci_beat_t;

  typedef struct packed {
    logic [`SPCI_BANK_W-1:0] bank;
    logic [`SPCI_ROW_W-1:0]  row;
    logic [`SPCI_COL_W-1:0]  col;
    logic                    auto_pre;
    logic                    row_open;
  } spci_addr_t;
endpackage : spci_pkg

// ==== hw/spci_fifo.sv ====
// Small FIFO carrying write beats toward the array
`timescale 1ns/1ps
module spci_fifo
  import spci_pkg::*;
#(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } spci_fifo_st_t;

  logic [WIDTH-1:0] mem [DEPTH];
  spci_fifo_st_t    st_r;
  spci_fifo_st_t    st_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data  = mem[st_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    case ({push, pop})
      2'b10:   st_nxt.cnt = st_r.cnt + 1'b1;
      2'b01:   st_nxt.cnt = st_r.cnt - 1'b1;
      default: st_nxt.cnt = st_r.cnt;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
    if (push) begin
      mem[st_r.wp] <= in_data;
    end
  end
endmodule : spci_fifo

// ==== hw/spci_top.sv ====
// Device-side pin command interface of a four-bank 16-bit SDRAM
`timescale 1ns/1ps
`include "spci_defines.svh"
module spci_top
  import spci_pkg::*;
#(
  parameter int DATA_W = `SPCI_DATA_W,
  parameter int ROW_W  = `SPCI_ROW_W,
  parameter int COL_W  = `SPCI_COL_W,
  parameter int BANK_W = `SPCI_BANK_W
) (
  input  wire logic              REF_CLK,
  input  wire logic              NRST,
  input  wire logic              CLOCK_GATE,
  input  wire logic              SELECT_N,
  input  wire logic              ROW_STROBE_N,
  input  wire logic              COL_STROBE_N,
  input  wire logic              WRITE_STROBE_N,
  input  wire logic [ROW_W-1:0]  ADDRESS_LINES,
  input  wire logic [BANK_W-1:0] BANK_SELECT,
  input  wire logic              LOW_BYTE_MASK,
  input  wire logic              HIGH_BYTE_MASK,
  input  wire logic [DATA_W-1:0] DATA_LINES_IN,
  output logic      [DATA_W-1:0] DATA_LINES_OUT,
  output logic      [1:0]        DATA_LINES_OE,
  input  wire logic [DATA_W-1:0] RD_DATA,
  output logic                   RD_REQ,
  output logic                   WR_VALID,
  input  wire logic              WR_READY,
  output logic      [DATA_W-1:0] WR_DATA,
  output logic      [1:0]        WR_BYTE_EN,
  output logic      [BANK_W-1:0] ACC_BANK,
  output logic      [ROW_W-1:0]  ACC_ROW,
  output logic      [COL_W-1:0]  ACC_COL,
  output logic                   ACC_AUTO_PRE,
  output logic      [2:0]        CMD_CODE,
  output logic                   CMD_PULSE,
  output logic      [1:0]        POWER_MODE,
  output logic                   CMD_LOST
);
  // Package structs fix the field widths
  if (DATA_W != `SPCI_DATA_W || ROW_W != `SPCI_ROW_W
      || COL_W != `SPCI_COL_W || BANK_W != `SPCI_BANK_W
      || COL_W > ROW_W || ROW_W <= `SPCI_PRE_BIT) begin : g_bad_width
    $error("Unsupported width parameters");
  end

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers and state

  typedef struct packed {
    logic                     gate_s1;
    logic                     gate_s2;
    logic                     gate_d;
    spci_mode_t               mode;
    spci_addr_t               addr;
    logic [1:0]               rd_act;
    logic [1:0][1:0]          rd_mask;
    logic                     wr_act;
    logic [DATA_W-1:0]        dq_out;
    logic [1:0]               dq_oe;
    logic                     rd_req;
    spci_cmd_t                cmd;
    logic                     cmd_pulse;
    logic                     lost;
    logic [1:0]               exit_cnt;
  } spci_st_t;

  spci_st_t   st_r;
  spci_st_t   st_nxt;
  spci_cmd_t  cmd_dec;
  logic       edge_ok;
  logic       sel;
  logic [1:0] mask_in;
  spci_beat_t wbeat;
  spci_beat_t wbeat_q;
  logic       wq_valid;
  logic       wq_ready;
  logic       w_push;

  assign mask_in = {HIGH_BYTE_MASK, LOW_BYTE_MASK};
  // Gate is caught off-edge through its own synchroniser
  assign edge_ok = st_r.gate_s2;
  assign sel     = edge_ok && !SELECT_N;

  ////////////////////////////////////////////////////////////////////////
  // Command decode from the three strobes together

  always_comb begin
    unique case ({ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N})
      3'h0: cmd_dec = SPCI_CMD_LMR;
      3'h1: cmd_dec = SPCI_CMD_REF;
      3'h2: cmd_dec = SPCI_CMD_PRE;
      3'h3: cmd_dec = SPCI_CMD_ACT;
      3'h4: cmd_dec = SPCI_CMD_WR;
      3'h5: cmd_dec = SPCI_CMD_RD;
      3'h6: cmd_dec = SPCI_CMD_BST;
      3'h7: cmd_dec = SPCI_CMD_NOP;
    endcase
  end

  // Write beat with same-cycle masks into the FIFO
  assign wbeat.data = DATA_LINES_IN;
  assign wbeat.mask = mask_in;
  assign w_push     = edge_ok && st_r.wr_act;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt           = st_r;
    st_nxt.gate_s1   = CLOCK_GATE;
    st_nxt.gate_s2   = st_r.gate_s1;
    st_nxt.gate_d    = st_r.gate_s2;
    st_nxt.cmd_pulse = 1'b0;
    st_nxt.rd_req    = 1'b0;
    st_nxt.lost      = 1'b0;
    if (!edge_ok) begin
      // Frozen edge: mode chosen by activity at the fall
      if (st_r.gate_d) begin
        if (st_r.rd_act != '0 || st_r.wr_act) begin
          st_nxt.mode = SPCI_SUSPEND;
        end else if (!SELECT_N && cmd_dec == SPCI_CMD_REF) begin
          st_nxt.mode = SPCI_SELF_REFRESH;
        end else begin
          st_nxt.mode = SPCI_POWER_DOWN;
        end
      end
    end else begin
      st_nxt.mode = SPCI_RUN;
      if (st_r.exit_cnt != '0) begin
        st_nxt.exit_cnt = st_r.exit_cnt - 1'b1;
      end
      if (!st_r.gate_d && st_r.mode == SPCI_SELF_REFRESH) begin
        st_nxt.exit_cnt = 2'(`SPCI_EXIT_NOPS);
      end
      // Read pipe: mask sampled now is applied two edges on
      st_nxt.rd_act  = {st_r.rd_act[0], 1'b0};
      st_nxt.rd_mask = {st_r.rd_mask[0], mask_in};
      st_nxt.dq_oe   = '0;
      if (st_r.rd_act[1]) begin
        st_nxt.dq_out = RD_DATA;
        st_nxt.dq_oe  = ~st_r.rd_mask[1];
      end
      st_nxt.wr_act = 1'b0;
      if (sel) begin
        st_nxt.cmd       = cmd_dec;
        st_nxt.cmd_pulse = (cmd_dec != SPCI_CMD_NOP);
        unique case (cmd_dec)
          SPCI_CMD_ACT: begin
            st_nxt.addr.bank     = BANK_SELECT;
            st_nxt.addr.row      = ADDRESS_LINES;
            st_nxt.addr.row_open = 1'b1;
          end
          SPCI_CMD_RD, SPCI_CMD_WR: begin
            st_nxt.addr.bank     = BANK_SELECT;
            st_nxt.addr.col      = ADDRESS_LINES[COL_W-1:0];
            st_nxt.addr.auto_pre = ADDRESS_LINES[`SPCI_PRE_BIT];
            if (cmd_dec == SPCI_CMD_RD) begin
              st_nxt.rd_act[0] = 1'b1;
              st_nxt.rd_req    = 1'b1;
            end else begin
              st_nxt.wr_act = 1'b1;
            end
          end
          SPCI_CMD_PRE: st_nxt.addr.row_open = 1'b0;
          default: ;
        endcase
      end
      // Beat dropped when the write FIFO is full and cannot take it
      if (w_push && !wq_ready) begin
        st_nxt.lost = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      st_r      <= '0;
      st_r.cmd  <= SPCI_CMD_NOP;
      st_r.mode <= SPCI_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write path through FIFO

  spci_fifo #(
    .WIDTH ($bits(spci_beat_t)),
    .DEPTH (`SPCI_FIFO_DEPTH)
  ) u_wfifo (
    .clk       (REF_CLK),
    .rst_n     (NRST),
    .in_valid  (w_push),
    .in_ready  (wq_ready),
    .in_data   (wbeat),
    .out_valid (wq_valid),
    .out_ready (WR_READY),
    .out_data  (wbeat_q)
  );

  assign WR_VALID   = wq_valid;
  assign WR_DATA    = wbeat_q.data;
  assign WR_BYTE_EN = ~wbeat_q.mask;

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign DATA_LINES_OUT = st_r.dq_out;
  assign DATA_LINES_OE  = st_r.dq_oe;
  assign RD_REQ         = st_r.rd_req;
  assign ACC_BANK       = st_r.addr.bank;
  assign ACC_ROW        = st_r.addr.row;
  assign ACC_COL        = st_r.addr.col;
  assign ACC_AUTO_PRE   = st_r.addr.auto_pre;
  assign CMD_CODE       = st_r.cmd;
  assign CMD_PULSE      = st_r.cmd_pulse;
  assign POWER_MODE     = st_r.mode;
  assign CMD_LOST       = st_r.lost;
endmodule : spci_top

// ==== test/spci_props.sv ====
// Assertions on the pin command interface ports
`timescale 1ns/1ps
module spci_props
  import spci_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        NRST,
  input wire logic        SELECT_N,
  input wire logic [11:0] ADDRESS_LINES,
  input wire logic [1:0]  BANK_SELECT,
  input wire logic        LOW_BYTE_MASK,
  input wire logic        HIGH_BYTE_MASK,
  input wire logic [1:0]  DATA_LINES_OE,
  input wire logic        RD_REQ,
  input wire logic [1:0]  ACC_BANK,
  input wire logic [11:0] ACC_ROW,
  input wire logic [7:0]  ACC_COL,
  input wire logic        ACC_AUTO_PRE,
  input wire logic [2:0]  CMD_CODE,
  input wire logic        CMD_PULSE,
  input wire logic [1:0]  POWER_MODE,
  input wire logic        CMD_LOST
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  desel_quiet_a: assert property ($past(SELECT_N) |-> !CMD_PULSE)
    else $error("pulse after deselected edge");
  desel_hold_a: assert property ($past(SELECT_N) |->
    $stable(ACC_ROW) && $stable(ACC_COL) && $stable(ACC_BANK))
    else $error("address moved while deselected");
  pulse_real_a: assert property (
    CMD_PULSE |-> CMD_CODE != SPCI_CMD_NOP)
    else $error("pulse carries no-op code");
  row_capture_a: assert property (
    CMD_PULSE && CMD_CODE == SPCI_CMD_ACT |->
    ACC_ROW == $past(ADDRESS_LINES) && ACC_BANK == $past(BANK_SELECT))
    else $error("row or bank not captured");
  col_capture_a: assert property (
    CMD_PULSE && CMD_CODE == SPCI_CMD_RD |->
    ACC_COL == $past(ADDRESS_LINES[7:0])
    && ACC_AUTO_PRE == $past(ADDRESS_LINES[10]))
    else $error("column not captured");
  rd_request_a: assert property (
    CMD_PULSE && CMD_CODE == SPCI_CMD_RD |-> RD_REQ)
    else $error("read request missing");
  rd_lane_oe_a: assert property (
    CMD_PULSE && CMD_CODE == SPCI_CMD_RD |->
    ##2 DATA_LINES_OE == ~$past({HIGH_BYTE_MASK, LOW_BYTE_MASK}, 3))
    else $error("lane enable not from read-edge mask");
  frozen_quiet_a: assert property (POWER_MODE != 2'h0 |-> !CMD_PULSE)
    else $error("command accepted while frozen");
  cover property (CMD_PULSE && CMD_CODE == SPCI_CMD_ACT);
  cover property (DATA_LINES_OE == 2'h1);
  cover property (CMD_LOST);
  cover property (POWER_MODE != 2'h0);
endmodule : spci_props

bind spci_top spci_props u_props (
  .REF_CLK, .NRST, .SELECT_N, .ADDRESS_LINES, .BANK_SELECT,
  .LOW_BYTE_MASK, .HIGH_BYTE_MASK, .DATA_LINES_OE, .RD_REQ,
  .ACC_BANK, .ACC_ROW, .ACC_COL, .ACC_AUTO_PRE, .CMD_CODE,
  .CMD_PULSE, .POWER_MODE, .CMD_LOST
);

// ==== test/spci_ctrl_model.sv ====
// Memory controller model driving the command pins
`timescale 1ns/1ps
module spci_ctrl_model (
  output logic        SELECT_N,
  output logic        ROW_STROBE_N,
  output logic        COL_STROBE_N,
  output logic        WRITE_STROBE_N,
  output logic [11:0] ADDRESS_LINES,
  output logic [1:0]  BANK_SELECT,
  output logic        LOW_BYTE_MASK,
  output logic        HIGH_BYTE_MASK,
  output logic [15:0] DATA_LINES_IN
);
  task automatic put(logic s, logic [2:0] c, logic [11:0] a,
                     logic [1:0] b, logic [1:0] m, logic [15:0] d);
    SELECT_N = s;
    {ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N} = c;
    ADDRESS_LINES = a;
    BANK_SELECT = b;
    {HIGH_BYTE_MASK, LOW_BYTE_MASK} = m;
    DATA_LINES_IN = d;
  endtask : put
  // Idle address, bank and data lines flip so a stale value never passes; masks are random
  task automatic idle;
    put(1'b0, 3'h7, ~ADDRESS_LINES, ~BANK_SELECT, 2'($urandom),
        ~DATA_LINES_IN);
  endtask : idle
endmodule : spci_ctrl_model

// ==== test/tb.sv ====
// Self-checking bench for the pin command interface
`timescale 1ns/1ps
module tb
  import spci_pkg::*;
;
  logic        REF_CLK, NRST, CLOCK_GATE, WR_READY, stall;
  logic [15:0] RD_DATA;
  wire         SELECT_N, ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N;
  wire         LOW_BYTE_MASK, HIGH_BYTE_MASK, RD_REQ, WR_VALID;
  wire         ACC_AUTO_PRE, CMD_PULSE, CMD_LOST;
  wire [11:0]  ADDRESS_LINES, ACC_ROW;
  wire [15:0]  DATA_LINES_IN, DATA_LINES_OUT, WR_DATA;
  wire [1:0]   BANK_SELECT, DATA_LINES_OE, WR_BYTE_EN, ACC_BANK, POWER_MODE;
  wire [7:0]   ACC_COL;
  wire [2:0]   CMD_CODE;
  int          num_errors, checks, lost_seen, lost_exp;
  logic [17:0] exp_q[$];
  spci_top u_spci_top (.REF_CLK, .NRST, .CLOCK_GATE, .SELECT_N,
    .ROW_STROBE_N, .COL_STROBE_N, .WRITE_STROBE_N, .ADDRESS_LINES,
    .BANK_SELECT, .LOW_BYTE_MASK, .HIGH_BYTE_MASK, .DATA_LINES_IN,
    .DATA_LINES_OUT, .DATA_LINES_OE, .RD_DATA, .RD_REQ, .WR_VALID,
    .WR_READY, .WR_DATA, .WR_BYTE_EN, .ACC_BANK, .ACC_ROW, .ACC_COL,
    .ACC_AUTO_PRE, .CMD_CODE, .CMD_PULSE, .POWER_MODE, .CMD_LOST);
  spci_ctrl_model u_ctrl (.SELECT_N, .ROW_STROBE_N, .COL_STROBE_N,
    .WRITE_STROBE_N, .ADDRESS_LINES, .BANK_SELECT, .LOW_BYTE_MASK,
    .HIGH_BYTE_MASK, .DATA_LINES_IN);
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lanes(logic [1:0] en);
    return {{8{en[1]}}, {8{en[0]}}};
  endfunction : lanes
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic close_out;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic tick(int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : tick
  // Beat follows its command by one edge, mask in the same cycle
  task automatic wr(logic [1:0] m, logic [15:0] d);
    u_ctrl.put(1'b0, SPCI_CMD_WR, 12'($urandom), 2'h2, 2'($urandom), ~d);
    tick(1);
    u_ctrl.put(1'b0, SPCI_CMD_NOP, 12'($urandom), 2'h2, m, d);
    if (exp_q.size() >= 4) lost_exp++;
    else exp_q.push_back({d & lanes(~m), ~m});
    tick(1);
  endtask : wr
  task automatic drain;
    for (int i = 0; i < 60 && exp_q.size() > 0; i++) tick(1);
    cmp("drain left", 32'h0, 32'(exp_q.size()));
  endtask : drain
  ////////////////////////////////////////////////////////////////
  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end
  // Random array stall; full stall only where fill is tested
  always @(posedge REF_CLK) #1 WR_READY = !stall && ($urandom % 4 != 0);
  always @(posedge REF_CLK) begin
    if (NRST && CMD_LOST === 1'b1) lost_seen++;
    if (NRST && WR_VALID === 1'b1 && WR_READY === 1'b1) begin
      if (exp_q.size() == 0) cmp("extra beat", 32'h0, 32'h1);
      else cmp("wr beat", 32'(exp_q[0]), 32'({WR_DATA &
        lanes(exp_q[0][1:0]), WR_BYTE_EN}));
      if (exp_q.size() > 0) exp_q.pop_front();
    end
  end
  initial begin
    logic [11:0] a;
    logic [15:0] d;
    void'($urandom(7429));
    NRST = 1'b0; CLOCK_GATE = 1'b1; WR_READY = 1'b0; stall = 1'b0;
    RD_DATA = 16'h0;
    u_ctrl.put(1'b1, SPCI_CMD_NOP, 12'h0, 2'h0, 2'h0, 16'h0);
    tick(3); NRST = 1'b1; tick(3);
    repeat (4) begin
      a = 12'($urandom);
      u_ctrl.put(1'b0, SPCI_CMD_ACT, a, a[1:0], 2'h0, 16'h0);
      tick(1); cmp("act", 32'({a[1:0], a}), 32'({ACC_BANK, ACC_ROW}));
      u_ctrl.put(1'b1, SPCI_CMD_ACT, ~a, ~a[1:0], 2'h0, 16'h0);
      tick(1); cmp("desel", 32'({a, 1'b0}), 32'({ACC_ROW, CMD_PULSE}));
    end
    for (int c = 0; c < 8; c++) begin
      if (c == 4) continue;
      u_ctrl.put(1'b0, 3'(c), 12'h0, 2'h0, 2'h3, 16'h0);
      tick(1); u_ctrl.idle();
      cmp("cmd", 32'({c != 7, 3'(c)}), 32'({CMD_PULSE, CMD_CODE}));
      tick(1);
    end
    for (int k = 0; k < 4; k++) begin
      a = 12'($urandom); d = 16'($urandom);
      u_ctrl.put(1'b0, SPCI_CMD_RD, a, 2'h1, 2'(k), 16'h0);
      tick(1); u_ctrl.idle();
      cmp("rd col", 32'({1'b1, a[10], a[7:0]}),
          32'({RD_REQ, ACC_AUTO_PRE, ACC_COL}));
      tick(1); RD_DATA = d;
      tick(1); RD_DATA = ~d;
      cmp("rd lanes", 32'({~2'(k), d & lanes(~2'(k))}), 32'({DATA_LINES_OE,
          DATA_LINES_OUT & lanes(~2'(k))}));
    end
    for (int k = 0; k < 8; k++) begin
      wr(2'(k), 16'($urandom)); u_ctrl.idle(); tick(2);
    end
    drain(); stall = 1'b1; tick(2);
    repeat (5) begin
      wr(2'($urandom), 16'($urandom)); u_ctrl.idle(); tick(1);
    end
    tick(2); cmp("lost", 32'(lost_exp), 32'(lost_seen));
    stall = 1'b0; drain();
    // Gate moves off the clock grid: it is asynchronous
    #23 CLOCK_GATE = 1'b0; tick(4);
    cmp("mode", 32'(SPCI_POWER_DOWN), 32'(POWER_MODE));
    u_ctrl.put(1'b0, SPCI_CMD_ACT, 12'hABC, 2'h3, 2'h0, 16'h0);
    tick(1); u_ctrl.idle();
    cmp("gated", 32'h0, 32'({ACC_ROW, CMD_PULSE}));
    #17 CLOCK_GATE = 1'b1; tick(6);
    u_ctrl.put(1'b0, SPCI_CMD_ACT, 12'hABC, 2'h3, 2'h0, 16'h0);
    tick(1); u_ctrl.idle();
    cmp("resume", 32'({2'h0, 12'hABC}), 32'({POWER_MODE, ACC_ROW}));
    // First frozen edge: refresh gives self refresh, open read suspend
    for (int s = 0; s < 2; s++) begin
      u_ctrl.put(1'b0, s ? SPCI_CMD_RD : SPCI_CMD_REF, 12'h0, 2'h0, 2'h3,
                 16'h0);
      #23 CLOCK_GATE = 1'b0; tick(4);
      cmp("frozen mode", 32'(s ? SPCI_SUSPEND : SPCI_SELF_REFRESH),
          32'(POWER_MODE));
      u_ctrl.idle(); #17 CLOCK_GATE = 1'b1; tick(6);
      cmp("thawed mode", 32'(SPCI_RUN), 32'(POWER_MODE));
    end
    NRST = 1'b0; tick(3);
    cmp("reset", 32'({SPCI_CMD_NOP, 2'h0}), 32'({CMD_CODE, POWER_MODE}));
    close_out();
  end
endmodule : tb
